// ### src/ccc_pkg.sv
// Purpose: Shared constants of the codec configuration command block
// Assumes: 20 MHz system clock
// Notes: Coefficient words use one sign bit and a three bit shift per term
package ccc_pkg;
	// ****************************************************************
	// Opcodes
	// ****************************************************************
	localparam logic [7:0] OP_REC_WR = 8'h9a;
	localparam logic [7:0] OP_REC_RD = 8'h9b;
	localparam logic [7:0] OP_DEB_WR = 8'hc8;
	localparam logic [7:0] OP_DEB_RD = 8'hc9;
	localparam logic [7:0] OP_TXS_RD = 8'hcd;
	localparam logic [7:0] OP_GND_WR = 8'he8;
	localparam logic [7:0] OP_GND_RD = 8'he9;
	// ****************************************************************
	// Byte counts
	// ****************************************************************
	localparam logic [2:0] REC_BYTES = 3'h5;
	localparam logic [2:0] TXS_BYTES = 3'h2;
	localparam logic [2:0] ONE_BYTE = 3'h1;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] COEF_RST = 16'h0190;
	localparam logic [7:0] SCALE_RST = 8'h90;
	localparam logic [7:0] DEB_RST = 8'h20;
	localparam logic [3:0] GND_RST = 4'h0;
	// ****************************************************************
	// Debounce and timing option fields
	// ****************************************************************
	localparam int DEB_MUX_BIT = 7;
	localparam int DEB_POL_BIT = 6;
	localparam int DEB_HOOK_LSB = 2;
	localparam int DEB_DCLK_BIT = 1;
	localparam int DEB_CHOP_BIT = 0;
	// ****************************************************************
	// Coefficient term fields, term k at bits 4k+3 (sign), 4k+2:4k
	// ****************************************************************
	localparam int TERM_BITS = 4;
	localparam int SHIFT_BITS = 3;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_PERIOD_NS = 31250;
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CHOP_HALF_CYCLES = 39;
endpackage : ccc_pkg

// ### src/ccc_csd_mult.sv
// Purpose: Multiply a sample by a nested signed power-of-two coefficient
// Assumes: Sign bit 0 means plus one, 1 means minus one
// Notes: Purely combinational
module ccc_csd_mult
	import ccc_pkg::*;
#(
	parameter int TERMS = 4,
	parameter int W = 20
) (
	input wire logic [TERMS*TERM_BITS-1:0] coef,
	input wire logic signed [W-1:0] x,
	output logic signed [W-1:0] y
);
	logic signed [W-1:0] acc;
	logic signed [W-1:0] sh;
	logic sgn;
	logic [SHIFT_BITS-1:0] m;

	// Innermost term first, then wrap outward
	always_comb begin
		acc = x;
		sh = '0;
		sgn = 1'b0;
		m = '0;
		for (int k = TERMS - 1; k >= 0; k--) begin
			sgn = coef[k*TERM_BITS+SHIFT_BITS];
			m = coef[k*TERM_BITS +: SHIFT_BITS];
			sh = acc >>> m;
			if (sgn) begin
				sh = -sh;
			end
			acc = (k == 0) ? sh : W'(x + sh);
		end
		y = acc;
	end
endmodule : ccc_csd_mult

// ### src/ccc_debounce.sv
// Purpose: Stability filter for one detector input
// Assumes: Input already synchronised, msTick is one cycle wide
// Notes: A period of zero passes the input straight through
module ccc_debounce
	import ccc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic msTick,
	input wire logic [3:0] period,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic [3:0] cnt;
		logic out;
	} cccdb_s;

	cccdb_s st_r;
	cccdb_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (din == st_r.out) begin
			st_nxt.cnt = '0;
		end else if (period == 4'h0) begin
			st_nxt.out = din;
			st_nxt.cnt = '0;
		end else if (msTick) begin
			if (st_r.cnt + 4'h1 >= period) begin
				st_nxt.out = din;
				st_nxt.cnt = '0;
			end else begin
				st_nxt.cnt = st_r.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.out;
endmodule : ccc_debounce

// ### src/ccc_config_cmd.sv
// Purpose: Host command interpreter for shaping, timing and filter options
// Assumes: Byte strobes come from host port logic on clk_sys
// Notes: Detector pins are asynchronous and are synchronised here
module ccc_config_cmd
	import ccc_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int DW = 16,
	parameter int MS_COUNT = MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [7:0] rxByte,
	input wire logic rxValid,
	input wire logic rxFirst,
	input wire logic rdReq,
	output logic [7:0] txByte,
	output logic txValid,
	input wire logic [CHANNELS-1:0] chanEnable,
	input wire logic hostPortMode,
	input wire logic linearMode,
	input wire logic [DW-1:0] transmitSample,
	input wire logic signed [DW-1:0] voiceIn,
	output logic signed [DW-1:0] recursiveOut,
	input wire logic channelOutputMode,
	output logic sequencingStrobe,
	output logic doubleHighwayClock,
	output logic chopperClockOut,
	input wire logic [CHANNELS-1:0] hookDetectorIn,
	input wire logic [CHANNELS-1:0] groundKeyDetectorIn,
	output logic [CHANNELS-1:0] hookRealTime,
	output logic [CHANNELS-1:0] groundKeyRealTime
);
	localparam int W = DW + 4;
	localparam int CW = $clog2(MS_COUNT + 1);
	localparam int SW = $clog2(SAMPLE_CYCLES + 1);
	localparam int HW = $clog2(CHOP_HALF_CYCLES + 1);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic [2:0] {
		CCC_IDLE = 3'b001,
		CCC_WR = 3'b010,
		CCC_RD = 3'b100
	} ccc_state_e;

	typedef struct packed {
		ccc_state_e fsm;
		logic [7:0] op;
		logic [2:0] idx;
		logic [7:0] shadow0;
		logic [7:0] shadow1;
		logic [7:0] shadow2;
		logic [7:0] shadow3;
		logic [15:0] z5;
		logic [7:0] z6;
		logic [15:0] z7;
		logic [7:0] options;
		logic [CHANNELS*4-1:0] gnd;
		logic [7:0] txb;
		logic txv;
		logic [CW-1:0] msCnt;
		logic msTick;
		logic [SW-1:0] smpCnt;
		logic smpTick;
		logic signed [W-1:0] recState;
		logic signed [DW-1:0] recOut;
		logic strobe;
		logic dclk;
		logic [HW-1:0] chopCnt;
		logic chop;
		logic [CHANNELS-1:0] hookS1;
		logic [CHANNELS-1:0] hookS2;
		logic [CHANNELS-1:0] gndS1;
		logic [CHANNELS-1:0] gndS2;
		logic [CHANNELS-1:0] hookRt;
		logic [CHANNELS-1:0] gndRt;
	} ccc_s;

	ccc_s st_r;
	ccc_s st_nxt;

	logic signed [W-1:0] z5Prod;
	logic signed [W-1:0] z7Prod;
	logic signed [W-1:0] z6Prod;
	logic [CHANNELS-1:0] hookFilt;
	logic [CHANNELS-1:0] gndFilt;
	logic [3:0] gndSel;
	logic signed [W-1:0] voiceWide;
	logic [2:0] lastIdx;

	// ****************************************************************
	// Recursive section arithmetic
	// ****************************************************************
	assign voiceWide = W'(voiceIn);

	// Input already carries the 1/z6 gain inside z5
	ccc_csd_mult #(.TERMS(4), .W(W)) u_z5 (
		.coef(st_r.z5),
		.x(voiceWide),
		.y(z5Prod)
	);

	ccc_csd_mult #(.TERMS(4), .W(W)) u_z7 (
		.coef(st_r.z7),
		.x(st_r.recState),
		.y(z7Prod)
	);

	ccc_csd_mult #(.TERMS(2), .W(W)) u_z6 (
		.coef(st_r.z6),
		.x(st_r.recState),
		.y(z6Prod)
	);

	// ****************************************************************
	// Detector filters
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_ch
			ccc_debounce u_hook (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.clkEn(clkEn),
				.msTick(st_r.msTick),
				.period(st_r.options[DEB_HOOK_LSB +: 4]),
				.din(st_r.hookS2[g]),
				.dout(hookFilt[g])
			);
			ccc_debounce u_gnd (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.clkEn(clkEn),
				.msTick(st_r.msTick),
				.period(st_r.gnd[g*4 +: 4]),
				.din(st_r.gndS2[g]),
				.dout(gndFilt[g])
			);
		end
	endgenerate

	// Lowest enabled channel answers a ground key read
	always_comb begin
		gndSel = '0;
		for (int c = CHANNELS - 1; c >= 0; c--) begin
			if (chanEnable[c]) begin
				gndSel = st_r.gnd[c*4 +: 4];
			end
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.txv = 1'b0;
		lastIdx = '0;

		// Timebases
		st_nxt.msTick = 1'b0;
		if (st_r.msCnt == CW'(MS_COUNT - 1)) begin
			st_nxt.msCnt = '0;
			st_nxt.msTick = 1'b1;
		end else begin
			st_nxt.msCnt = st_r.msCnt + CW'(1);
		end
		st_nxt.smpTick = 1'b0;
		if (st_r.smpCnt == SW'(SAMPLE_CYCLES - 1)) begin
			st_nxt.smpCnt = '0;
			st_nxt.smpTick = 1'b1;
		end else begin
			st_nxt.smpCnt = st_r.smpCnt + SW'(1);
		end

		// Recursive filter: v = z5*x + z7*v', out = z6*v'
		if (st_r.smpTick) begin
			st_nxt.recState = W'(z5Prod + z7Prod);
			if (z6Prod > W'(32767)) begin
				st_nxt.recOut = 16'sh7fff;
			end else if (z6Prod < -W'(32768)) begin
				st_nxt.recOut = -16'sh8000;
			end else begin
				st_nxt.recOut = DW'(z6Prod);
			end
		end

		// Sequencing strobe
		st_nxt.strobe = st_r.options[DEB_POL_BIT];
		if (channelOutputMode && st_r.options[DEB_MUX_BIT] &&
				st_r.smpTick) begin
			st_nxt.strobe = ~st_r.options[DEB_POL_BIT];
		end

		st_nxt.dclk = st_r.options[DEB_DCLK_BIT];

		// Chopper clock
		if (st_r.options[DEB_CHOP_BIT]) begin
			if (st_r.chopCnt == HW'(CHOP_HALF_CYCLES - 1)) begin
				st_nxt.chopCnt = '0;
				st_nxt.chop = ~st_r.chop;
			end else begin
				st_nxt.chopCnt = st_r.chopCnt + HW'(1);
			end
		end else begin
			st_nxt.chopCnt = '0;
			st_nxt.chop = 1'b0;
		end

		// Pin synchronisers
		st_nxt.hookS1 = hookDetectorIn;
		st_nxt.hookS2 = st_r.hookS1;
		st_nxt.gndS1 = groundKeyDetectorIn;
		st_nxt.gndS2 = st_r.gndS1;
		st_nxt.hookRt = hookFilt;
		st_nxt.gndRt = gndFilt;

		// Command interpreter
		if (rxValid && rxFirst) begin
			st_nxt.op = rxByte;
			st_nxt.idx = '0;
			unique case (rxByte)
				OP_REC_WR, OP_DEB_WR, OP_GND_WR: begin
					st_nxt.fsm = CCC_WR;
				end
				OP_REC_RD, OP_DEB_RD, OP_GND_RD: begin
					st_nxt.fsm = CCC_RD;
				end
				OP_TXS_RD: begin
					st_nxt.fsm = hostPortMode ? CCC_RD : CCC_IDLE;
				end
				default: begin
					st_nxt.fsm = CCC_IDLE;
				end
			endcase
		end else begin
			unique case (st_r.fsm)
				CCC_IDLE: begin
				end
				CCC_WR: begin
					if (rxValid) begin
						lastIdx = (st_r.op == OP_REC_WR) ?
							REC_BYTES - 3'h1 : ONE_BYTE - 3'h1;
						st_nxt.idx = st_r.idx + 3'h1;
						unique case (st_r.idx)
							3'h0: st_nxt.shadow0 = rxByte;
							3'h1: st_nxt.shadow1 = rxByte;
							3'h2: st_nxt.shadow2 = rxByte;
							3'h3: st_nxt.shadow3 = rxByte;
							default: begin
							end
						endcase
						if (st_r.idx == lastIdx) begin
							st_nxt.fsm = CCC_IDLE;
							if (st_r.op == OP_REC_WR) begin
								st_nxt.z5 = {st_r.shadow0, st_r.shadow1};
								st_nxt.z6 = st_r.shadow2;
								st_nxt.z7 = {st_r.shadow3, rxByte};
							end else if (st_r.op == OP_DEB_WR) begin
								st_nxt.options = rxByte;
							end else begin
								for (int c = 0; c < CHANNELS; c++) begin
									if (chanEnable[c]) begin
										st_nxt.gnd[c*4 +: 4] = rxByte[3:0];
									end
								end
							end
						end
					end
				end
				CCC_RD: begin
					if (rdReq) begin
						st_nxt.txv = 1'b1;
						st_nxt.idx = st_r.idx + 3'h1;
						lastIdx = ONE_BYTE - 3'h1;
						st_nxt.txb = 8'h00;
						if (st_r.op == OP_REC_RD) begin
							lastIdx = REC_BYTES - 3'h1;
							unique case (st_r.idx)
								3'h0: st_nxt.txb = st_r.z5[15:8];
								3'h1: st_nxt.txb = st_r.z5[7:0];
								3'h2: st_nxt.txb = st_r.z6;
								3'h3: st_nxt.txb = st_r.z7[15:8];
								default: st_nxt.txb = st_r.z7[7:0];
							endcase
						end else if (st_r.op == OP_DEB_RD) begin
							st_nxt.txb = st_r.options;
						end else if (st_r.op == OP_GND_RD) begin
							st_nxt.txb = {4'h0, gndSel};
						end else begin
							lastIdx = TXS_BYTES - 3'h1;
							if (st_r.idx == 3'h0) begin
								// Compressed code sits in the low byte
								st_nxt.txb = linearMode ?
									transmitSample[DW-1 -: 8] :
									transmitSample[7:0];
							end else begin
								st_nxt.txb = 8'h00;
							end
						end
						if (st_r.idx == lastIdx) begin
							st_nxt.fsm = CCC_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.fsm <= CCC_IDLE;
			st_r.z5 <= COEF_RST;
			st_r.z6 <= SCALE_RST;
			st_r.z7 <= COEF_RST;
			st_r.options <= DEB_RST;
			st_r.gnd <= {CHANNELS{GND_RST}};
			st_r.strobe <= DEB_RST[DEB_POL_BIT];
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign txByte = st_r.txb;
	assign txValid = st_r.txv;
	assign recursiveOut = st_r.recOut;
	assign sequencingStrobe = st_r.strobe;
	assign doubleHighwayClock = st_r.dclk;
	assign chopperClockOut = st_r.chop;
	assign hookRealTime = st_r.hookRt;
	assign groundKeyRealTime = st_r.gndRt;
endmodule : ccc_config_cmd

// ### tb/ccc_config_cmd_assertions.sv
// Purpose: Port-level checks of the configuration command block
// Assumes: One clock domain, clkEn high while a read is answered
// Notes: Bound to the design from the testbench top file
module ccc_config_cmd_assertions
	import ccc_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int DW = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic rxValid,
	input wire logic rdReq,
	input wire logic txValid,
	input wire logic channelOutputMode,
	input wire logic sequencingStrobe,
	input wire logic doubleHighwayClock,
	input wire logic chopperClockOut,
	input wire logic [CHANNELS-1:0] hookDetectorIn,
	input wire logic [CHANNELS-1:0] groundKeyDetectorIn,
	input wire logic [CHANNELS-1:0] hookRealTime,
	input wire logic [CHANNELS-1:0] groundKeyRealTime,
	input wire logic signed [DW-1:0] recursiveOut
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ****************************************************************
	// Gap between changes of the filter output
	// ****************************************************************
	logic signed [DW-1:0] recPrev_r;
	logic [9:0] recGap_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			recPrev_r <= '0;
			recGap_r <= 10'h3ff;
		end else begin
			recPrev_r <= recursiveOut;
			if (recursiveOut != recPrev_r)
				recGap_r <= 10'h000;
			else if (recGap_r != 10'h3ff)
				recGap_r <= recGap_r + 10'h001;
		end
	end
	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_txv_cause;
		txValid |-> $past(rdReq);
	endproperty
	a_txv_cause: assert property (p_txv_cause)
		else $error("read byte without request");
	property p_dclk;
		$changed(doubleHighwayClock) |-> $past(rxValid) || $past(rxValid, 2);
	endproperty
	a_dclk: assert property (p_dclk)
		else $error("highway clock option changed without a write");
	property p_seq_none;
		!channelOutputMode && !$past(channelOutputMode)
			&& !$past(channelOutputMode, 2) && !$past(rxValid)
			&& !$past(rxValid, 2) && !$past(rxValid, 3)
			|-> $stable(sequencingStrobe);
	endproperty
	a_seq_none: assert property (p_seq_none)
		else $error("strobe moved while output mode is off");
	property p_seq_gap;
		$changed(sequencingStrobe) && !$past(rxValid) && !$past(rxValid, 2)
			&& !$past(rxValid, 3) ##1 $stable(sequencingStrobe)
			|=> $stable(sequencingStrobe)[*7];
	endproperty
	a_seq_gap: assert property (p_seq_gap)
		else $error("strobe pulses too close");
	property p_chop;
		$rose(chopperClockOut) |=> chopperClockOut[*8];
	endproperty
	a_chop: assert property (p_chop)
		else $error("chopper high phase too short");
	property p_hook;
		$changed(hookRealTime) |-> ((hookRealTime ^ $past(hookRealTime))
			& (hookRealTime ^ hookDetectorIn)) == '0;
	endproperty
	a_hook: assert property (p_hook)
		else $error("hook bit moved away from its pin");
	property p_gnd;
		$changed(groundKeyRealTime)
			|-> ((groundKeyRealTime ^ $past(groundKeyRealTime))
			& (groundKeyRealTime ^ groundKeyDetectorIn)) == '0;
	endproperty
	a_gnd: assert property (p_gnd)
		else $error("ground key bit moved away from its pin");
	property p_rec_gap;
		(recursiveOut != recPrev_r) |-> recGap_r >= 10'h270;
	endproperty
	a_rec_gap: assert property (p_rec_gap)
		else $error("filter output updated faster than sample rate");
endmodule : ccc_config_cmd_assertions

// ### tb/ccc_host_model.sv
// Purpose: Host side of the command port
// Assumes: Tasks are entered just after a rising edge
// Notes: Released byte lines show the inverse of the last byte
module ccc_host_model (
	input wire logic clk_sys,
	output logic [7:0] rxByte,
	output logic rxValid,
	output logic rxFirst,
	output logic rdReq,
	input wire logic [7:0] txByte,
	input wire logic txValid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rxByte = 8'h00;
		rxValid = 1'b0;
		rxFirst = 1'b0;
		rdReq = 1'b0;
	end
	// Opcode then data bytes back to back
	task automatic wr(input logic [7:0] op, input logic [7:0] q[$]);
		@(posedge clk_sys);
		rxByte <= op;
		rxValid <= 1'b1;
		rxFirst <= 1'b1;
		foreach (q[i]) begin
			@(posedge clk_sys);
			rxFirst <= 1'b0;
			rxByte <= q[i];
		end
		@(posedge clk_sys);
		rxValid <= 1'b0;
		rxFirst <= 1'b0;
		rxByte <= ~rxByte;
	endtask : wr
	// Unanswered bytes come back unknown
	task automatic rd(input logic [7:0] op, input int n,
		output logic [7:0] q[$]);
		q = {};
		@(posedge clk_sys);
		rxByte <= op;
		rxValid <= 1'b1;
		rxFirst <= 1'b1;
		@(posedge clk_sys);
		rxValid <= 1'b0;
		rxFirst <= 1'b0;
		rxByte <= ~op;
		repeat (n) begin
			rdReq <= 1'b1;
			@(posedge clk_sys);
			rdReq <= 1'b0;
			@(posedge clk_sys);
			q.push_back(txValid === 1'b1 ? txByte : 8'hxx);
		end
	endtask : rd
endmodule : ccc_host_model

// ### tb/ccc_config_cmd_tb.sv
// Purpose: Self-checking bench of the configuration command block
// Assumes: Millisecond timebase shortened to 20 clocks
// Notes: Host traffic goes through the host model tasks
module ccc_config_cmd_tb
	import ccc_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CH = 4;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic [7:0] rxByte, txByte;
	logic rxValid, rxFirst, rdReq, txValid, seqStb, dhc, chop;
	logic hostPortMode = 1'b1;
	logic linearMode = 1'b0;
	logic com = 1'b0;
	logic [CH-1:0] chanEnable = '0;
	logic [CH-1:0] hookIn = '0;
	logic [CH-1:0] gndIn = '0;
	logic [CH-1:0] hookRt, gndRt;
	logic [15:0] sample = 16'ha55a;
	logic signed [15:0] voiceIn = 16'sh1234;
	logic signed [15:0] recOut;
	logic [7:0] bq[$];
	logic [7:0] fq[$];
	logic [7:0] got[$];
	logic [7:0] optT[4] = '{8'h03, 8'hc1, 8'hc0, 8'h82};
	logic comT[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	int fails = 0;
	int checked = 0;
	always #25 clk_sys = ~clk_sys;
	ccc_config_cmd #(.CHANNELS(CH), .DW(16), .MS_COUNT(20)) ccc_config_cmd_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .rxByte(rxByte),
		.rxValid(rxValid), .rxFirst(rxFirst), .rdReq(rdReq),
		.txByte(txByte), .txValid(txValid), .chanEnable(chanEnable),
		.hostPortMode(hostPortMode), .linearMode(linearMode),
		.transmitSample(sample), .voiceIn(voiceIn), .recursiveOut(recOut),
		.channelOutputMode(com), .sequencingStrobe(seqStb),
		.doubleHighwayClock(dhc), .chopperClockOut(chop),
		.hookDetectorIn(hookIn), .groundKeyDetectorIn(gndIn),
		.hookRealTime(hookRt), .groundKeyRealTime(gndRt));
	ccc_host_model ccc_host_model_i (.clk_sys(clk_sys), .rxByte(rxByte),
		.rxValid(rxValid), .rxFirst(rxFirst), .rdReq(rdReq),
		.txByte(txByte), .txValid(txValid));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic rdc(input string nm, input logic [7:0] op,
		input logic [7:0] e[$]);
		ccc_host_model_i.rd(op, e.size(), got);
		foreach (e[i]) check(nm, {8'h00, got[i]}, {8'h00, e[i]});
	endtask : rdc
	// Cycles until a real-time bit goes high
	task automatic lag(input int b, input logic gnd, output int n);
		for (n = 0; n < 300; n++) begin
			@(posedge clk_sys);
			if ((gnd ? gndRt[b] : hookRt[b]) === 1'b1) break;
		end
	endtask : lag
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		#2500000;
		fails++;
		wrap_up();
	end
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		int act, tog, n;
		logic last;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		chanEnable <= 4'h1;
		bq = '{DEB_RST};
		rdc("opt0", OP_DEB_RD, bq);
		fq = '{8'h01, 8'h90, SCALE_RST, 8'h01, 8'h90};
		rdc("rec0", OP_REC_RD, fq);
		bq = '{8'h00};
		rdc("gnd0", OP_GND_RD, bq);
		repeat (1300) @(posedge clk_sys);
		check("recz", recOut, 16'h0000);
		fq = '{8'h09, 8'h00, 8'h01, 8'h01, 8'h90};
		ccc_host_model_i.wr(OP_REC_WR, fq);
		repeat (1900) @(posedge clk_sys);
		check("recp", recOut, 16'h1234);
		bq = '{8'h09, 8'h08};
		ccc_host_model_i.wr(OP_REC_WR, bq);
		rdc("abort", OP_REC_RD, fq);
		fq[1] = 8'h08;
		ccc_host_model_i.wr(OP_REC_WR, fq);
		repeat (1900) @(posedge clk_sys);
		check("recn", recOut, 16'hedcc);
		for (int k = 0; k < 4; k++) begin
			// Write just after a fall so a turn-off never cuts a high phase
			for (int w = 0; w < 80 && chop !== 1'b1; w++) @(posedge clk_sys);
			for (int w = 0; w < 80 && chop === 1'b1; w++) @(posedge clk_sys);
			com <= comT[k];
			bq = '{optT[k]};
			ccc_host_model_i.wr(OP_DEB_WR, bq);
			rdc("opt", OP_DEB_RD, bq);
			repeat (2) @(posedge clk_sys);
			act = 0;
			tog = 0;
			last = chop;
			repeat (700) begin
				@(posedge clk_sys);
				act += (seqStb !== optT[k][6]);
				tog += (chop !== last);
				last = chop;
			end
			check("dhc", dhc, optT[k][1]);
			check("stb", (optT[k][7] & comT[k]) ? (act == 1 || act == 2)
				: act == 0, 1);
			check("chop", optT[k][0] ? (tog >= 17 && tog <= 18)
				: tog == 0, 1);
		end
		bq = '{8'h0c};
		ccc_host_model_i.wr(OP_DEB_WR, bq);
		hookIn[0] <= 1'b1;
		repeat (30) @(posedge clk_sys);
		hookIn[0] <= 1'b0;
		repeat (40) @(posedge clk_sys);
		check("glitch", hookRt[0], 0);
		hookIn[0] <= 1'b1;
		lag(0, 1'b0, n);
		check("hook3", n >= 40 && n <= 66, 1);
		bq = '{8'h00};
		ccc_host_model_i.wr(OP_DEB_WR, bq);
		hookIn[1] <= 1'b1;
		lag(1, 1'b0, n);
		check("hook0", n <= 6, 1);
		chanEnable <= 4'h3;
		bq = '{8'h02};
		ccc_host_model_i.wr(OP_GND_WR, bq);
		chanEnable <= 4'h4;
		bq = '{8'h00};
		ccc_host_model_i.wr(OP_GND_WR, bq);
		chanEnable <= 4'h2;
		bq = '{8'h02};
		rdc("gnd", OP_GND_RD, bq);
		gndIn[0] <= 1'b1;
		lag(0, 1'b1, n);
		check("gnd2", n >= 20 && n <= 46, 1);
		gndIn[2] <= 1'b1;
		lag(2, 1'b1, n);
		check("gndoff", n <= 6, 1);
		chanEnable <= 4'h0;
		bq = '{8'h00};
		rdc("optg", OP_DEB_RD, bq);
		bq = '{8'h5a, 8'h00};
		rdc("cmp", OP_TXS_RD, bq);
		linearMode <= 1'b1;
		bq = '{8'ha5, 8'h00};
		rdc("lin", OP_TXS_RD, bq);
		hostPortMode <= 1'b0;
		bq = '{8'hxx};
		rdc("off", OP_TXS_RD, bq);
		rdc("bad", 8'h55, bq);
		// A write while the clock enable is low must not land
		clkEn <= 1'b0;
		bq = '{8'h01};
		ccc_host_model_i.wr(OP_DEB_WR, bq);
		clkEn <= 1'b1;
		bq = '{8'h00};
		rdc("frz", OP_DEB_RD, bq);
		wrap_up();
	end
endmodule : ccc_config_cmd_tb
bind ccc_config_cmd ccc_config_cmd_assertions #(.CHANNELS(CHANNELS),
	.DW(DW)) ccc_config_cmd_assertions_i (.clk_sys(clk_sys),
	.rst_n(rst_n), .rxValid(rxValid), .rdReq(rdReq), .txValid(txValid),
	.channelOutputMode(channelOutputMode),
	.sequencingStrobe(sequencingStrobe),
	.doubleHighwayClock(doubleHighwayClock),
	.chopperClockOut(chopperClockOut), .hookDetectorIn(hookDetectorIn),
	.groundKeyDetectorIn(groundKeyDetectorIn),
	.hookRealTime(hookRealTime), .groundKeyRealTime(groundKeyRealTime),
	.recursiveOut(recursiveOut));
